// [src/dpll_consts.svh]
// constants for the digital phase-locked loop core
// assumes inclusion by bare name from the package and the core
`ifndef DPLL_CONSTS_SVH
`define DPLL_CONSTS_SVH
`define DPLL_CNT_W 17
`define DPLL_MOD_OFF 2
`define DPLL_SEL_INHIBIT 4'h0
`define DPLL_CLK_NS 50
`define DPLL_RST_CNT 17'h00000
`define DPLL_INS_TOGGLES 2'h2
`endif

// [src/dpll_core.sv]
// digital phase-locked loop core: detectors, modulus counter, pulse adjust
// assumes one ref_clk domain; the pulse-adjust and counter clocks arrive as pins
// Functional notes
// - xor detector output high when its two inputs differ
// - edge detector output low on a falling edge of input a; rising edges hold
// - all modulus select bits low inhibits counter, no carry or borrow
// - select n gives modulus 2 to the power n plus two
// - modulus select may change while running
// - selected detector output sets count direction; counter steps on counter clock
// - carry pulse on wrap while counting up
// - borrow pulse on wrap while counting down
// - idle output toggles on each pulse-adjust clock rise, a square wave at half its rate
// - each carry or borrow inserts or removes one output pulse; of several before one adjust-clock rise only the last takes effect
// - zero error xor inputs quarter cycle apart, output square wave
// - zero error edge inputs half cycle apart
`timescale 1ns/10ps
`default_nettype none
`include "dpll_consts.svh"
module dpll_core (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire dpll_pkg::dpll_phase_in_type phase_in,
    input wire logic [3:0] modulus_select,
    input wire logic use_edge_detector,
    input wire logic counter_clock,
    input wire logic pulse_adjust_clock,
    output var dpll_pkg::dpll_detect_out_type detect_out,
    output logic carry,
    output logic borrow,
    output logic pulse_adjust_output
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 5;
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] prev_q;
    logic [3:0] sel1_q;
    logic [3:0] sel_q;
    assign pin_raw = {pulse_adjust_clock, counter_clock, phase_in};
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
            sel1_q <= 4'h0;
            sel_q <= 4'h0;
        end else if (clk_en) begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            sel1_q <= modulus_select;
            sel_q <= sel1_q;
        end
    end
    logic [SYNC_W-1:0] fall;
    logic [SYNC_W-1:0] rise;
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_edge
            assign fall[gi] = prev_q[gi] & ~sync2_q[gi];
            assign rise[gi] = ~prev_q[gi] & sync2_q[gi];
        end
    endgenerate
    // bit order follows the struct: b=0, edge a=1, xor a=2, counter=3, adjust=4
    logic b_fall;
    logic ea_fall;
    logic kclk_rise;
    logic aclk_rise;
    logic aclk_fall;
    assign b_fall = fall[0];
    assign ea_fall = fall[1];
    assign kclk_rise = rise[3];
    assign aclk_rise = rise[4];
    assign aclk_fall = fall[4];
    // ------------------------------------------------------------
    // phase detectors
    // ------------------------------------------------------------
    logic xor_q;
    logic edge_q;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            xor_q <= 1'b0;
        end else if (clk_en) begin
            xor_q <= sync2_q[2] ^ sync2_q[0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            edge_q <= 1'b0;
        end else if (clk_en) begin
            // b falling wins if both fall together
            if (b_fall) begin
                edge_q <= 1'b1;
            end else if (ea_fall) begin
                edge_q <= 1'b0;
            end
        end
    end
    assign detect_out.exclusive_or_detector_output = xor_q;
    assign detect_out.edge_detector_output = edge_q;
    // ------------------------------------------------------------
    // modulus counter
    // ------------------------------------------------------------
    function automatic logic [`DPLL_CNT_W-1:0] top_of(input logic [3:0] sel);
        logic [`DPLL_CNT_W-1:0] one;
        one = {{(`DPLL_CNT_W-1){1'b0}}, 1'b1};
        top_of = (one << (5'(sel) + 5'(`DPLL_MOD_OFF))) - one;
    endfunction
    logic count_down;
    logic inhibit;
    logic [`DPLL_CNT_W-1:0] top;
    logic [`DPLL_CNT_W-1:0] cnt_q;
    logic carry_q;
    logic borrow_q;
    assign count_down = use_edge_detector ? edge_q : xor_q;
    assign inhibit = (sel_q == `DPLL_SEL_INHIBIT);
    assign top = top_of(sel_q);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q <= `DPLL_RST_CNT;
            carry_q <= 1'b0;
            borrow_q <= 1'b0;
        end else if (clk_en) begin
            carry_q <= 1'b0;
            borrow_q <= 1'b0;
            if (inhibit) begin
                cnt_q <= `DPLL_RST_CNT;
            end else if (kclk_rise) begin
                if (count_down) begin
                    if (cnt_q == '0) begin
                        cnt_q <= top;
                        borrow_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end else begin
                    // a shrunk modulus wraps at once, no stall
                    if (cnt_q >= top) begin
                        cnt_q <= '0;
                        carry_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
            end
        end
    end
    assign carry = carry_q;
    assign borrow = borrow_q;
    // ------------------------------------------------------------
    // pulse adjust
    // ------------------------------------------------------------
    // each output pulse spans two toggles: insert adds two toggles on the
    // next two adjust-clock falls, delete skips two adjust-clock rises
    dpll_pkg::dpll_adj_type pend_q;
    logic out_q;
    logic hold_q;
    logic [1:0] extra_q;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_q <= dpll_pkg::DPLL_ADJ_IDLE;
            out_q <= 1'b0;
            hold_q <= 1'b0;
            extra_q <= 2'h0;
        end else if (clk_en) begin
            if (carry_q) begin
                pend_q <= dpll_pkg::DPLL_ADJ_INSERT;
            end else if (borrow_q) begin
                pend_q <= dpll_pkg::DPLL_ADJ_DELETE;
            end
            if (aclk_rise) begin
                case (pend_q)
                    dpll_pkg::DPLL_ADJ_IDLE: begin
                        if (hold_q) begin
                            hold_q <= 1'b0;
                        end else begin
                            out_q <= ~out_q;
                        end
                    end
                    dpll_pkg::DPLL_ADJ_INSERT: begin
                        // normal step now, the extra pulse follows on the falls
                        if (hold_q) begin
                            hold_q <= 1'b0;
                        end else begin
                            out_q <= ~out_q;
                        end
                        extra_q <= `DPLL_INS_TOGGLES;
                        if (!carry_q && !borrow_q) begin
                            pend_q <= dpll_pkg::DPLL_ADJ_IDLE;
                        end
                    end
                    dpll_pkg::DPLL_ADJ_DELETE: begin
                        hold_q <= 1'b1;
                        if (!carry_q && !borrow_q) begin
                            pend_q <= dpll_pkg::DPLL_ADJ_IDLE;
                        end
                    end
                    default: begin
                        pend_q <= dpll_pkg::DPLL_ADJ_IDLE;
                    end
                endcase
            end else if (aclk_fall && extra_q != 2'h0) begin
                out_q <= ~out_q;
                extra_q <= extra_q - 2'h1;
            end
        end
    end
    assign pulse_adjust_output = out_q;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_carry_seen;
        carry_q ##1 (pend_q == dpll_pkg::DPLL_ADJ_INSERT);
    endsequence
    a_xor_output: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en |=> (xor_q == ($past(sync2_q[2]) ^ $past(sync2_q[0]))))
        else $error("xor detector output wrong");
    a_edge_low: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && ea_fall && !b_fall) |=> !edge_q)
        else $error("edge detector not low after a fall");
    a_edge_high: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && b_fall) |=> edge_q)
        else $error("edge detector not high after b fall");
    a_inhibit_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && inhibit) |=> (!carry_q && !borrow_q))
        else $error("pulse while inhibited");
    a_carry_wrap: assert property (@(posedge ref_clk) disable iff (rst)
        carry_q |-> (cnt_q == '0))
        else $error("carry without wrap to zero");
    a_borrow_wrap: assert property (@(posedge ref_clk) disable iff (rst)
        borrow_q |-> (cnt_q == $past(top)))
        else $error("borrow without wrap to top");
    a_carry_insert: assert property (@(posedge ref_clk) disable iff (rst)
        (carry_q && clk_en) |=> (pend_q == dpll_pkg::DPLL_ADJ_INSERT))
        else $error("carry not queued as insert");
    a_idle_toggle: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && aclk_rise && pend_q == dpll_pkg::DPLL_ADJ_IDLE && !hold_q) |=> (out_q != $past(out_q)))
        else $error("idle output did not toggle");
    a_delete_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && aclk_rise && pend_q == dpll_pkg::DPLL_ADJ_DELETE) |=> (hold_q && out_q == $past(out_q)))
        else $error("delete did not hold output");
    a_count_dir: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && kclk_rise && !inhibit && !count_down && cnt_q < top) |=> (cnt_q == $past(cnt_q) + 1'b1))
        else $error("counter did not count up");
    // a rise and a fall of one pin never land in one cycle
    sequence s_insert_start;
        clk_en && aclk_rise && (pend_q == dpll_pkg::DPLL_ADJ_INSERT);
    endsequence
    sequence s_extra_fall;
        clk_en && aclk_fall && (extra_q != 2'h0);
    endsequence
    a_insert_arm: assert property (@(posedge ref_clk) disable iff (rst)
        s_insert_start |=> (extra_q == `DPLL_INS_TOGGLES))
        else $error("insert did not arm extra toggles");
    a_extra_toggle: assert property (@(posedge ref_clk) disable iff (rst)
        s_extra_fall |=> (out_q != $past(out_q)))
        else $error("extra toggle missing");
    a_borrow_delete: assert property (@(posedge ref_clk) disable iff (rst)
        (borrow_q && clk_en) |=> (pend_q == dpll_pkg::DPLL_ADJ_DELETE))
        else $error("borrow not queued as delete");
    a_pend_clear: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && aclk_rise && pend_q != dpll_pkg::DPLL_ADJ_IDLE && !carry_q && !borrow_q) |=> (pend_q == dpll_pkg::DPLL_ADJ_IDLE))
        else $error("pending adjust applied twice");
    a_hold_still: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && !aclk_rise && !aclk_fall) |=> $stable(out_q))
        else $error("output moved without adjust clock edge");
    a_count_down: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && kclk_rise && !inhibit && count_down && cnt_q != '0) |=> (cnt_q == $past(cnt_q) - 1'b1))
        else $error("counter did not count down");
    a_carry_top: assert property (@(posedge ref_clk) disable iff (rst)
        (carry_q && $past(clk_en)) |-> ($past(cnt_q) >= $past(top)))
        else $error("carry before the modulus top");
    a_carry_once: assert property (@(posedge ref_clk) disable iff (rst)
        (carry_q && clk_en) |=> !carry_q)
        else $error("carry longer than one cycle");
    a_borrow_once: assert property (@(posedge ref_clk) disable iff (rst)
        (borrow_q && clk_en) |=> !borrow_q)
        else $error("borrow longer than one cycle");
    a_pulse_excl: assert property (@(posedge ref_clk) disable iff (rst)
        !(carry_q && borrow_q))
        else $error("carry and borrow together");
    a_inhibit_zero: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && inhibit) |=> (cnt_q == '0))
        else $error("inhibited counter not held at zero");
    a_edge_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (clk_en && !ea_fall && !b_fall) |=> $stable(edge_q))
        else $error("edge detector moved without a fall");
    a_freeze_state: assert property (@(posedge ref_clk) disable iff (rst)
        !clk_en |=> ($stable(cnt_q) && $stable(out_q) && $stable(pend_q) && $stable(edge_q) && $stable(xor_q)))
        else $error("state moved while clock enable low");
    a_select_follow: assert property (@(posedge ref_clk) disable iff (rst)
        (!$past(rst) && !$past(rst, 2) && $past(clk_en) && $past(clk_en, 2))
            |-> (sel_q == $past(modulus_select, 2)))
        else $error("modulus select not followed");
    a_insert_seen: cover property (@(posedge ref_clk) disable iff (rst) s_carry_seen);
endmodule // dpll_core
`default_nettype wire

// [src/dpll_pkg.sv]
// types for the digital phase-locked loop core
// assumes dpll_consts.svh on the include path
`include "dpll_consts.svh"
package dpll_pkg;
    typedef struct packed {
        logic xor_detector_input_a;
        logic edge_detector_input_a;
        logic phase_b;
    } dpll_phase_in_type;
    typedef struct packed {
        logic exclusive_or_detector_output;
        logic edge_detector_output;
    } dpll_detect_out_type;
    typedef enum logic [1:0] {
        DPLL_ADJ_IDLE = 2'b00,
        DPLL_ADJ_INSERT = 2'b01,
        DPLL_ADJ_DELETE = 2'b10
    } dpll_adj_type;
endpackage

// [verif/dpll_far_end.sv]
// far side: pulse-adjust clock source and divide-by-n feedback counter
// assumes ref_clk from the bench; loop_en routes the divider onto phase b
`timescale 1ns/10ps
`default_nettype none
module dpll_far_end #(
    parameter int DIV_N = 4
) (
    input wire logic ref_clk,
    input wire logic loop_en,
    input wire logic manual_b,
    input wire logic adj_out,
    output logic adj_clk,
    output logic phase_b
);
    logic [2:0] ph_q = 3'h0;
    logic last_q = 1'b0;
    logic fb_q = 1'b0;
    int div_q = 0;
    // adjust clock at ref_clk/8, well under the ref_clk/4 ceiling
    assign adj_clk = ph_q[2];
    assign phase_b = loop_en ? fb_q : manual_b;
    always @(posedge ref_clk) begin
        ph_q <= ph_q + 3'h1;
        last_q <= adj_out;
        if (adj_out && !last_q) begin
            div_q <= (div_q + 1) % (DIV_N / 2);
            if (div_q == DIV_N / 2 - 1) fb_q <= ~fb_q;
        end
    end
endmodule // dpll_far_end
`default_nettype wire

// [verif/tb_top.sv]
// bench for the phase-locked loop core: detectors, modulus counter, pulse adjust
// assumes dpll_pkg and dpll_far_end compiled before this file
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic use_edge = 1'b0;
    logic counter_clock = 1'b0;
    logic loop_en = 1'b0;
    logic man_b = 1'b0;
    logic xa = 1'b0;
    logic ea = 1'b0;
    logic edge_m = 1'b0;
    logic prev_out = 1'b0;
    logic prev_clk = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rng = 32'h0d87;
    logic carry, borrow, adj_out, adj_clk, fb_b;
    dpll_pkg::dpll_phase_in_type pin;
    dpll_pkg::dpll_detect_out_type dout;
    int n_fail = 0;
    int samples_checked = 0;
    int n_car = 0, n_bor = 0, n_tog = 0, n_rise = 0;
    assign pin = {xa, ea, fb_b};
    always #25 ref_clk = ~ref_clk;
    dpll_core dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .phase_in(pin), .modulus_select(sel),
        .use_edge_detector(use_edge), .counter_clock(counter_clock), .pulse_adjust_clock(adj_clk),
        .detect_out(dout), .carry(carry), .borrow(borrow), .pulse_adjust_output(adj_out));
    dpll_far_end #(.DIV_N(4)) far (.ref_clk(ref_clk), .loop_en(loop_en), .manual_b(man_b),
        .adj_out(adj_out), .adj_clk(adj_clk), .phase_b(fb_b));
    // event counters seen at the ports
    always @(posedge ref_clk) begin
        prev_out <= adj_out;
        prev_clk <= adj_clk;
        if (carry === 1'b1) n_car <= n_car + 1;
        if (borrow === 1'b1) n_bor <= n_bor + 1;
        if (adj_out !== prev_out) n_tog <= n_tog + 1;
        if (adj_clk && !prev_clk) n_rise <= n_rise + 1;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic do_reset;
        rst = 1'b1;
        cyc(8);
        rst = 1'b0;
        cyc(2);
    endtask
    // park just before an adjust-clock rise so the toggle of every earlier rise has landed; a toggle from the last fall is still in flight
    task automatic sync_adj;
        int r;
        r = n_rise;
        for (int i = 0; i < 20 && n_rise == r; i++) cyc(1);
        if (n_rise == r) begin
            n_fail++;
            stop_test();
        end
        cyc(5);
    endtask
    task automatic pulses(input int k);
        repeat (k) begin
            counter_clock = 1'b1;
            cyc(2);
            counter_clock = 1'b0;
            cyc(2);
        end
    endtask
    task automatic run_cnt(input logic [3:0] n, input logic edge_sel, input logic down);
        int m, k, c0, b0, t0, r0, ec, eb;
        m = (n == 4'h0) ? 0 : (1 << (n + 2));
        k = (m == 0) ? 20 : 2 * m + 3;
        man_b = 1'b0;
        do_reset();
        use_edge = edge_sel;
        sel = n;
        xa = down ^ edge_sel;
        if (edge_sel && down) begin
            man_b = 1'b1;
            cyc(6);
            man_b = 1'b0;
        end
        cyc(6);
        sync_adj();
        c0 = n_car;
        b0 = n_bor;
        t0 = n_tog;
        r0 = n_rise;
        pulses(k);
        cyc(60);
        sync_adj();
        ec = (m == 0 || down) ? 0 : k / m;
        eb = (m == 0 || !down) ? 0 : (k + m - 1) / m;
        check(n_car - c0, ec, "carry count");
        check(n_bor - b0, eb, "borrow count");
        check(n_tog - t0, (n_rise - r0) + 2 * ec - 2 * eb, "output toggles");
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int c0, b0, t0, r0;
        do_reset();
        for (int i = 0; i < 48; i++) begin
            rng = xs(rng);
            if (ea && !rng[1]) edge_m = 1'b0;
            if (man_b && !rng[2]) edge_m = 1'b1;
            xa = rng[0];
            ea = rng[1];
            man_b = rng[2];
            cyc(6);
            check(dout.exclusive_or_detector_output, xa ^ man_b, "xor detector");
            check(dout.edge_detector_output, edge_m, "edge detector");
        end
        // clock enable low: a changed input must not reach the outputs
        clk_en = 1'b0;
        xa = !xa;
        cyc(6);
        check(dout.exclusive_or_detector_output, !xa ^ man_b, "frozen xor");
        clk_en = 1'b1;
        cyc(6);
        check(dout.exclusive_or_detector_output, xa ^ man_b, "xor after freeze");
        for (int n = 0; n < 4; n++)
            for (int md = 0; md < 4; md++) run_cnt(n[3:0], md[1], md[0]);
        do_reset();
        loop_en = 1'b1;
        sel = 4'h3;
        sync_adj();
        c0 = n_car;
        b0 = n_bor;
        t0 = n_tog;
        r0 = n_rise;
        for (int i = 0; i < 24; i++) begin
            xa = i[2];
            if (i == 12) sel = 4'h1;
            pulses(8);
        end
        cyc(60);
        sync_adj();
        check(n_tog - t0, (n_rise - r0) + 2 * (n_car - c0) - 2 * (n_bor - b0), "loop toggles");
        stop_test();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
